// ### src/heartbeat_pkg.sv
// Package: constants and carrier types for heartbeat error control
package heartbeat_pkg;

	// ----------------------------------------
	// Object dictionary indexes and layout
	// ----------------------------------------
	localparam logic [15:0] IDX_CONSUMER = 16'h1016;
	localparam logic [15:0] IDX_PRODUCER = 16'h1017;
	localparam logic [15:0] IDX_COMM_LO = 16'h1000;
	localparam logic [15:0] IDX_COMM_HI = 16'h1FFF;
	localparam logic [15:0] IDX_MFR_LO = 16'h2000;
	localparam logic [7:0] SUB_COUNT = 8'h00;
	localparam logic [7:0] SUB_FIRST = 8'h01;
	localparam logic [7:0] CONSUMER_COUNT = 8'h02;
	localparam logic [7:0] PERIOD_RESET = 8'h00;
	localparam logic [31:0] ENTRY_RESET = 32'h0000_0000;
	localparam int ENTRY_NODE_LSB = 16;
	localparam int ENTRY_TIME_LSB = 0;

	// ----------------------------------------
	// Telegram encoding and node states
	// ----------------------------------------
	localparam logic [10:0] HB_COB_BASE = 11'h700;
	localparam logic [6:0] ST_STOPPED = 7'h04;
	localparam logic [6:0] ST_OPERATIONAL = 7'h05;
	localparam logic [6:0] ST_PREOP = 7'h7F;
	localparam logic [15:0] MIN_HB_MS = 16'h0002;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int TICK_MS = 1;
	localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;

	// Carrier for a consumer entry
	typedef struct packed {
		logic [7:0] reserved;
		logic [7:0] node;
		logic [15:0] time_ms;
	} consumer_entry_t;

	// Carrier for an object dictionary access
	typedef struct packed {
		logic write;
		logic [15:0] index;
		logic [7:0] sub;
		logic [31:0] data;
	} sdo_req_t;

	// Carrier for a received or sent CAN telegram
	typedef struct packed {
		logic [10:0] cob_id;
		logic [7:0] data;
	} can_frame_t;

endpackage : heartbeat_pkg

// ### src/heartbeat_error_control.sv
// Heartbeat producer and consumers with offline alarm for a slave node
// ----------------------------------------
// Block
// ----------------------------------------
// How it works
// - Two consumer entries sit at sub-indexes 1 and 2; sub 0 reads 2.
// - An entry splits into reserved[31:24], node[23:16], time[15:0].
// - Consumer time counts milliseconds; zero turns that entry off.
// - An entry starts timing only after its producer's first heartbeat.
// - A timeout forces pre-operational and raises the offline alarm.
// - A nonzero producer period sends a heartbeat every period ms.
// - A heartbeat uses 700h plus node id, one byte, bit 7 zero, state below.
// - Heartbeat keeps running while stopped as well.
// - Writing zero to period or a consumer time disables that function.
// - Reprogramming a service after a timeout clears the offline alarm.
// - Heartbeat times below 2 ms are refused.
// - Heartbeat is refused while node guarding is enabled.
// - Communication objects 1000h-1FFFh return to defaults on reset.
// - Objects from 2000h up live in nonvolatile store outside this block.
// - Process data may pass only when enabled and operational.
// - Node state codes: stopped 4, operational 5, pre-operational 127.
module heartbeat_error_control #(
	parameter int N_CONS = 2,
	parameter int MS_DIV = heartbeat_pkg::MS_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [6:0] node_id,
	input wire logic [6:0] node_state,
	input wire logic comm_enabled,
	input wire logic guarding_enabled,
	input wire logic sdo_valid,
	input wire heartbeat_pkg::sdo_req_t sdo_req,
	output logic sdo_ack,
	output logic sdo_abort,
	output logic [31:0] sdo_rdata,
	input wire logic rx_valid,
	input wire heartbeat_pkg::can_frame_t rx_frame,
	output logic tx_valid,
	input wire logic tx_ready,
	output heartbeat_pkg::can_frame_t tx_frame,
	output logic force_preop,
	output logic comm_offline_alarm,
	output logic pdo_allowed
);
	import heartbeat_pkg::*;

	consumer_entry_t entry_reg [N_CONS];
	logic [N_CONS-1:0] armed_reg;
	logic [N_CONS-1:0] timeout_evt;
	logic [15:0] cons_ms_reg [N_CONS];
	logic [7:0] period_reg;
	logic [7:0] prod_ms_reg;
	logic [$clog2(MS_DIV)-1:0] div_reg;
	logic ms_tick;
	logic is_cons;
	logic is_prod;
	logic [7:0] cons_sel;
	logic cons_hit;
	logic refuse;
	logic reprogram;
	logic [31:0] rdata_next;

	// ----------------------------------------
	// Millisecond tick
	// ----------------------------------------
	// Divider runs free so all timers share one time base
	always_ff @(posedge ref_clk) begin
		if (reset || ms_tick) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end
	assign ms_tick = (div_reg == ($clog2(MS_DIV))'(MS_DIV - 1));

	// ----------------------------------------
	// Object access decode
	// ----------------------------------------
	// Dictionary access decode; a refused write is aborted, not stored
	always_comb begin
		is_cons = (sdo_req.index == IDX_CONSUMER);
		is_prod = (sdo_req.index == IDX_PRODUCER);
		cons_sel = sdo_req.sub - SUB_FIRST;
		cons_hit = is_cons && (sdo_req.sub >= SUB_FIRST) &&
			(sdo_req.sub <= CONSUMER_COUNT);
		refuse = 1'b0;
		rdata_next = '0;
		if (is_cons && sdo_req.sub == SUB_COUNT) begin
			rdata_next = {24'h00_0000, CONSUMER_COUNT};
			refuse = sdo_req.write;
		end else if (cons_hit) begin
			rdata_next = entry_reg[cons_sel[0]];
			// Zero disables; below minimum or with guarding on is refused
			if (sdo_req.write && sdo_req.data[15:0] != 16'h0000) begin
				refuse = (sdo_req.data[15:0] < MIN_HB_MS) ||
					guarding_enabled;
			end
		end else if (is_prod && sdo_req.sub == SUB_COUNT) begin
			rdata_next = {24'h00_0000, period_reg};
			if (sdo_req.write && sdo_req.data[7:0] != 8'h00) begin
				refuse = ({8'h00, sdo_req.data[7:0]} < MIN_HB_MS) ||
					guarding_enabled;
			end
		end else if (sdo_req.index >= IDX_MFR_LO) begin
			// Parameters sit in the nonvolatile store, not in this block
			refuse = 1'b1;
		end else begin
			refuse = 1'b1;
		end
	end
	assign reprogram = sdo_valid && sdo_req.write && !refuse &&
		(cons_hit || is_prod);

	// Answer one cycle after the request
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sdo_ack <= 1'b0;
			sdo_abort <= 1'b0;
			sdo_rdata <= '0;
		end else begin
			sdo_ack <= sdo_valid && !refuse;
			sdo_abort <= sdo_valid && refuse;
			sdo_rdata <= (sdo_valid && !sdo_req.write) ? rdata_next : '0;
		end
	end

	// Producer period; volatile, back to default on reset
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			period_reg <= PERIOD_RESET;
		end else if (reprogram && is_prod) begin
			period_reg <= sdo_req.data[7:0];
		end
	end

	// ----------------------------------------
	// Consumers
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < N_CONS; g++) begin : g_cons
			logic wr_here;
			logic seen;
			assign wr_here = reprogram && cons_hit &&
				(cons_sel == 8'(g));
			// Match on the telegram from the programmed producer
			assign seen = rx_valid && rx_frame.cob_id ==
				(HB_COB_BASE | {3'b000, entry_reg[g].node});
			assign timeout_evt[g] = armed_reg[g] && ms_tick &&
				cons_ms_reg[g] == entry_reg[g].time_ms;

			// Entry store; volatile
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					entry_reg[g] <= ENTRY_RESET;
				end else if (wr_here) begin
					entry_reg[g] <= sdo_req.data;
				end
			end

			// Armed by the first heartbeat, disarmed by timeout or write
			always_ff @(posedge ref_clk) begin
				if (reset || wr_here || entry_reg[g].time_ms == 16'h0000) begin
					armed_reg[g] <= 1'b0;
				end else if (seen) begin
					armed_reg[g] <= 1'b1;
				end else if (timeout_evt[g]) begin
					armed_reg[g] <= 1'b0;
				end
			end

			// Milliseconds since last heartbeat; works in every state
			always_ff @(posedge ref_clk) begin
				if (reset || seen || !armed_reg[g]) begin
					cons_ms_reg[g] <= 16'h0000;
				end else if (ms_tick) begin
					cons_ms_reg[g] <= cons_ms_reg[g] + 16'h0001;
				end
			end

			a_cons_wait_first: assert property (@(posedge ref_clk)
				disable iff (reset)
				$rose(armed_reg[g]) |-> $past(seen))
				else $error("consumer armed without a heartbeat");

			a_cons_restart: assert property (@(posedge ref_clk)
				disable iff (reset)
				seen |=> cons_ms_reg[g] == 16'h0000)
				else $error("heartbeat did not restart the timer");

			a_cons_zero_off: assert property (@(posedge ref_clk)
				disable iff (reset)
				entry_reg[g].time_ms == 16'h0000 |-> !armed_reg[g])
				else $error("disabled consumer still armed");
		end
	endgenerate

	// ----------------------------------------
	// Alarm and state forcing
	// ----------------------------------------
	// Timeout raises the alarm and beats a same-cycle reprogram; any other accepted reprogram clears it
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			comm_offline_alarm <= 1'b0;
			force_preop <= 1'b0;
		end else begin
			force_preop <= |timeout_evt;
			if (|timeout_evt) begin
				comm_offline_alarm <= 1'b1;
			end else if (reprogram) begin
				comm_offline_alarm <= 1'b0;
			end
		end
	end

	// Process data gate
	assign pdo_allowed = comm_enabled &&
		node_state == ST_OPERATIONAL && !force_preop;

	// ----------------------------------------
	// Producer
	// ----------------------------------------
	// Period counter restarts on a new period so the first beat is full
	always_ff @(posedge ref_clk) begin
		if (reset || period_reg == 8'h00 || (reprogram && is_prod)) begin
			prod_ms_reg <= 8'h00;
		end else if (ms_tick) begin
			if (prod_ms_reg == period_reg - 8'h01) begin
				prod_ms_reg <= 8'h00;
			end else begin
				prod_ms_reg <= prod_ms_reg + 8'h01;
			end
		end
	end

	// Telegram held until the link takes it; no state gating
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx_valid <= 1'b0;
			tx_frame <= '0;
		end else if (period_reg != 8'h00 && ms_tick &&
			prod_ms_reg == period_reg - 8'h01) begin
			tx_valid <= 1'b1;
			tx_frame.cob_id <= HB_COB_BASE | {4'h0, node_id};
			tx_frame.data <= {1'b0, node_state};
		end else if (tx_ready) begin
			tx_valid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_timeout_alarm: assert property (@(posedge ref_clk)
		disable iff (reset)
		|timeout_evt |=> comm_offline_alarm && force_preop)
		else $error("timeout did not raise alarm");
	a_alarm_sticky: assert property (@(posedge ref_clk)
		disable iff (reset)
		comm_offline_alarm && !reprogram |=> comm_offline_alarm)
		else $error("alarm dropped without reprogram");
	a_tx_bit7_zero: assert property (@(posedge ref_clk)
		disable iff (reset)
		tx_valid |-> !tx_frame.data[7])
		else $error("heartbeat bit 7 set");
	a_tx_held: assert property (@(posedge ref_clk)
		disable iff (reset)
		tx_valid && !tx_ready |=> tx_valid)
		else $error("heartbeat dropped before the link took it");
	a_prod_off: assert property (@(posedge ref_clk)
		disable iff (reset)
		period_reg == 8'h00 && !tx_valid |=> !tx_valid)
		else $error("heartbeat sent with zero period");
	a_tick_single: assert property (@(posedge ref_clk)
		disable iff (reset)
		ms_tick |=> !ms_tick)
		else $error("millisecond tick wider than one cycle");
	a_pdo_gate: assert property (@(posedge ref_clk)
		disable iff (reset)
		pdo_allowed |-> comm_enabled && node_state == ST_OPERATIONAL)
		else $error("process data allowed outside operational");
	a_short_refused: assert property (@(posedge ref_clk)
		disable iff (reset)
		sdo_valid && sdo_req.write && is_prod && sdo_req.data[7:0] == 8'h01
		|=> sdo_abort && period_reg != 8'h01)
		else $error("period below minimum accepted");
	a_refused_kept: assert property (@(posedge ref_clk)
		disable iff (reset)
		sdo_valid && sdo_req.write && is_prod && refuse
		|=> $stable(period_reg))
		else $error("refused period write was stored");
	a_answer_once: assert property (@(posedge ref_clk)
		disable iff (reset)
		!(sdo_ack && sdo_abort))
		else $error("access both accepted and refused");
	a_count_ro: assert property (@(posedge ref_clk)
		disable iff (reset)
		sdo_valid && !sdo_req.write && is_cons && sdo_req.sub == SUB_COUNT
		|=> sdo_rdata == 32'h0000_0002)
		else $error("entry count wrong");
	a_alarm_clear: assert property (@(posedge ref_clk)
		disable iff (reset)
		comm_offline_alarm && reprogram && !(|timeout_evt)
		|=> !comm_offline_alarm)
		else $error("alarm kept after reprogram");
	a_guard_excl: assert property (@(posedge ref_clk)
		disable iff (reset)
		sdo_valid && sdo_req.write && guarding_enabled && is_prod &&
		sdo_req.data[7:0] != 8'h00 |=> sdo_abort)
		else $error("heartbeat enabled alongside guarding");

endmodule : heartbeat_error_control

// ### sim/hb_master_model.sv
// Model of the network master and remote nodes
module hb_master_model (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic hb_go,
	input wire logic [6:0] hb_node,
	input wire logic slow,
	output logic rx_valid,
	output heartbeat_pkg::can_frame_t rx_frame,
	output logic tx_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	import heartbeat_pkg::*;
	logic [1:0] stall;
	// -----------------
	// Telegrams
	// -----------------
	// One beat per request; idle lines toggle so stale values never match
	// Counter starts from reset so the slow link is known from the start
	always_ff @(posedge ref_clk) begin
		rx_valid <= hb_go && !reset;
		if (reset) begin
			stall <= 2'h0;
			rx_frame <= '0;
		end else begin
			stall <= stall + 2'h1;
			if (hb_go) begin
				rx_frame <= {HB_COB_BASE + 11'(hb_node), 1'b0,
					ST_OPERATIONAL};
			end else begin
				rx_frame <= ~rx_frame;
			end
		end
	end
	// Slow mode takes one frame in four cycles
	assign tx_ready = !slow || stall == 2'h3;
endmodule : hb_master_model

// ### sim/heartbeat_error_control_tb_top.sv
// Self-checking bench for heartbeat error control
module heartbeat_error_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import heartbeat_pkg::*;
	logic ref_clk = 0, reset = 1, comm_enabled = 0, guarding_enabled = 0;
	logic [6:0] node_id = 7'h11, node_state = ST_PREOP, hb_node = 0, cn;
	logic sdo_valid = 0, sdo_ack, sdo_abort, rx_valid, tx_valid, tx_ready;
	logic force_preop, comm_offline_alarm, pdo_allowed, hb_go = 0, slow = 0;
	sdo_req_t sdo_req = '0;
	can_frame_t rx_frame, tx_frame;
	logic [31:0] sdo_rdata;
	logic [33:0] e, exp_q[$];
	int error_cnt = 0, checks_done = 0, seed = 32'hBB0F, tx_cnt = 0;
	int preop_cnt = 0, d;
	heartbeat_error_control #(.MS_DIV(10)) heartbeat_error_control_i (
		.ref_clk(ref_clk), .reset(reset), .node_id(node_id),
		.node_state(node_state), .comm_enabled(comm_enabled),
		.guarding_enabled(guarding_enabled), .sdo_valid(sdo_valid),
		.sdo_req(sdo_req), .sdo_ack(sdo_ack), .sdo_abort(sdo_abort),
		.sdo_rdata(sdo_rdata), .rx_valid(rx_valid), .rx_frame(rx_frame),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_frame(tx_frame),
		.force_preop(force_preop), .comm_offline_alarm(comm_offline_alarm),
		.pdo_allowed(pdo_allowed));
	hb_master_model hb_master_model_i (.ref_clk(ref_clk), .reset(reset),
		.hb_go(hb_go), .hb_node(hb_node), .slow(slow), .rx_valid(rx_valid),
		.rx_frame(rx_frame), .tx_ready(tx_ready));
	// Clock, 100 ns period
	initial forever #50 ref_clk = ~ref_clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize;
		if (error_cnt == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	// Expectation is queued before the request so the watcher can pop it
	task automatic sdo(input logic wr, input logic [15:0] ix,
		input logic [7:0] sb, input logic [31:0] dt, input logic ab,
		input logic [31:0] rd);
		int n;
		exp_q.push_back({ab, !wr && !ab, rd});
		@(posedge ref_clk) #1;
		sdo_valid = 1;
		sdo_req = {wr, ix, sb, dt};
		@(posedge ref_clk) #1;
		sdo_valid = 0;
		for (n = 0; n < 4 && exp_q.size() != 0; n++) @(posedge ref_clk);
		#1;
		if (exp_q.size() != 0) begin
			error_cnt++;
			summarize();
		end
	endtask : sdo
	// Beats 1 ms apart from node hb_node
	task automatic beat(input int n);
		repeat (n) begin
			@(posedge ref_clk) #1 hb_go = 1;
			@(posedge ref_clk) #1 hb_go = 0;
			repeat (8) @(posedge ref_clk);
		end
	endtask : beat
	// -----------------
	// Watcher
	// -----------------
	always @(posedge ref_clk) begin
		if (sdo_ack === 1'b1 || sdo_abort === 1'b1) begin
			e = exp_q.pop_front();
			check(32'(sdo_abort), 32'(e[33]));
			if (e[32]) check(sdo_rdata, e[31:0]);
		end
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			tx_cnt++;
			check(32'(tx_frame), {13'h0, HB_COB_BASE + 11'(node_id), 1'b0,
				node_state});
		end
		if (force_preop === 1'b1) preop_cnt++;
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge ref_clk);
		error_cnt++;
		summarize();
	end
	// -----------------
	// Main sequence
	// -----------------
	initial begin
		repeat (4) @(posedge ref_clk);
		#1 reset = 0;
		node_id = 7'($random(seed)) | 7'h01;
		cn = 7'($random(seed)) | 7'h08;
		sdo(0, IDX_CONSUMER, 0, 0, 0, 32'h2);
		sdo(1, IDX_CONSUMER, 0, 5, 1, 0);
		sdo(0, IDX_CONSUMER, 3, 0, 1, 0);
		sdo(0, 16'h1018, 0, 0, 1, 0);
		sdo(0, IDX_MFR_LO, 0, 0, 1, 0);
		sdo(1, IDX_PRODUCER, 0, 1, 1, 0);
		sdo(1, IDX_CONSUMER, 2, {9'h0, cn, 16'h1}, 1, 0);
		for (int i = 0; i < 3; i++) begin
			#1;
			node_state = i == 0 ? ST_STOPPED : i == 1 ? ST_OPERATIONAL : ST_PREOP;
			slow = i == 2;
			d = tx_cnt;
			sdo(1, IDX_PRODUCER, 0, 3, 0, 0);
			repeat (100) @(posedge ref_clk);
			check(tx_cnt - d, 3);
			sdo(1, IDX_PRODUCER, 0, 0, 0, 0);
			d = tx_cnt;
			repeat (100) @(posedge ref_clk);
			check(tx_cnt - d, 0);
		end
		sdo(1, IDX_CONSUMER, 1, {9'h0, cn, 16'h3}, 0, 0);
		sdo(0, IDX_CONSUMER, 1, 0, 0, {9'h0, cn, 16'h3});
		hb_node = cn ^ 7'h01;
		beat(8);
		hb_node = cn;
		beat(10);
		check(preop_cnt, 0);
		repeat (60) @(posedge ref_clk);
		check(preop_cnt, 1);
		check(32'(comm_offline_alarm), 1);
		#1 guarding_enabled = 1;
		sdo(1, IDX_CONSUMER, 1, {9'h0, cn, 16'h5}, 1, 0);
		guarding_enabled = 0;
		sdo(1, IDX_CONSUMER, 1, {9'h0, cn, 16'h3}, 0, 0);
		check(32'(comm_offline_alarm), 0);
		sdo(1, IDX_CONSUMER, 2, {9'h0, cn ^ 7'h02, 16'h0}, 0, 0);
		hb_node = cn ^ 7'h02;
		beat(1);
		repeat (60) @(posedge ref_clk);
		check(preop_cnt, 1);
		#1 comm_enabled = 1;
		node_state = ST_OPERATIONAL;
		#1 check(32'(pdo_allowed), 1);
		node_state = ST_STOPPED;
		#1 check(32'(pdo_allowed), 0);
		sdo(1, IDX_PRODUCER, 0, 4, 0, 0);
		@(posedge ref_clk) #1 reset = 1;
		repeat (2) @(posedge ref_clk);
		#1 reset = 0;
		sdo(0, IDX_CONSUMER, 1, 0, 0, 0);
		sdo(0, IDX_PRODUCER, 0, 0, 0, 0);
		summarize();
	end
endmodule : heartbeat_error_control_tb_top
